// *** verilog/irr_defines.svh ***
// Purpose: Constants of the infrared remote pulse unit: register indexes, fields, resets.
// Assumes: Byte address of a register is four times its index on the APB.
// Notes: Every field resets to zero.
// Operation
// - Carrier clock divides bus clock by two to the code 0..14; code 15 stops it.
// - Length counter clock uses its own select with the same encoding.
// - Direction bit 1 selects receive, 0 selects transmit; resets to transmit.
// - Enable bit 1 starts the selected direction, 0 stops everything; resets to 0.
// - Four 16-bit registers at every second index, 0x5340 to 0x5346; reserved bits read zero.
// - Carrier low phase lasts low setting plus one carrier clocks; bits 13:8.
// - Carrier high phase lasts high setting plus one carrier clocks; bits 5:0.
// - Writing bits 15:8 loads the counter, which then counts down per length clock.
// - At zero the counter stops, holds zero and raises the underflow cause.
// - Transmit mode drives the level bit modulated by the carrier on the output pin.
// - Receive mode updates the level bit with the incoming pulse level.
// - Falling edge sets flag bit 10; writing 1 clears, writing 0 ignored.
// - Rising edge sets flag bit 9; writing 1 clears, writing 0 ignored.
// - Counter underflow sets flag bit 8; writing 1 clears, writing 0 ignored.
// - One request is raised while any flag and its enable bit are both set.
// - Receive samples input on carrier clock; edge needs two equal new samples.
`ifndef IRR_DEFINES_SVH
`define IRR_DEFINES_SVH

`define IRR_IDX_CONFIG 16'h5340
`define IRR_IDX_CARRIER 16'h5342
`define IRR_IDX_COUNTER 16'h5344
`define IRR_IDX_IRQ 16'h5346

`define IRR_CFG_CDIV_HI 15
`define IRR_CFG_CDIV_LO 12
`define IRR_CFG_LDIV_HI 11
`define IRR_CFG_LDIV_LO 8
`define IRR_CFG_DIR 1
`define IRR_CFG_EN 0
`define IRR_CAR_LO_HI 13
`define IRR_CAR_LO_LO 8
`define IRR_CAR_HI_HI 5
`define IRR_CAR_HI_LO 0
`define IRR_CNT_LEN_HI 15
`define IRR_CNT_LEN_LO 8
`define IRR_CNT_LEVEL 0
`define IRR_IRQ_FLAG_HI 10
`define IRR_IRQ_FLAG_LO 8
`define IRR_IRQ_EN_HI 2
`define IRR_IRQ_EN_LO 0

`define IRR_RST_DIV 4'h0
`define IRR_RST_LEN 8'h00
`define IRR_RST_CAR 6'h00
`define IRR_DIV_RESERVED 4'hf
`define IRR_DIV_WIDTH 14

`endif

// *** verilog/irr_pkg.sv ***
// Purpose: Types and shared helpers of the infrared remote pulse unit.
// Assumes: Nothing beyond the constants header.
// Notes: Carrier states are one-hot.
package irr_pkg;

   typedef enum logic [2:0] {
      IRR_CAR_IDLE = 3'b001,
      IRR_CAR_HIGH = 3'b010,
      IRR_CAR_LOW = 3'b100
   } irr_car_state_t;

   // Mask of low counter bits that must all be ones for a divided tick.
   function automatic logic [13:0] irr_div_mask(input logic [3:0] sel);
      logic [14:0] one_hot;
      one_hot = 15'h0001 << sel;
      return 14'(one_hot - 15'h0001);
   endfunction : irr_div_mask

endpackage : irr_pkg

// *** verilog/irr_clk_div.sv ***
// Purpose: Power-of-two divider giving a one-cycle tick enable.
// Assumes: The select stays stable while run is high.
// Notes: Counter restarts from zero whenever run falls, so phases are repeatable.
`include "irr_defines.svh"
module irr_clk_div (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic run,
   input wire logic [3:0] sel,
   output logic tick
);
   logic [`IRR_DIV_WIDTH-1:0] cnt_q;
   logic [13:0] mask;

   assign mask = irr_pkg::irr_div_mask(sel);
   // The reserved code gives no tick at all, freezing whatever it clocks.
   assign tick = run && (sel != `IRR_DIV_RESERVED) && ((cnt_q & mask) == mask);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= 14'h0000;
      end else if (ce) begin
         if (run) begin
            cnt_q <= cnt_q + 14'h0001;
         end else begin
            cnt_q <= 14'h0000;
         end
      end
   end
endmodule : irr_clk_div

// *** verilog/irr_carrier_gen.sv ***
// Purpose: Carrier waveform with programmable high and low phase lengths.
// Assumes: tick is a one-cycle enable at the carrier clock rate.
// Notes: Each burst starts with a high phase in the cycle after run rises.
module irr_carrier_gen (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic run,
   input wire logic tick,
   input wire logic [5:0] high_len,
   input wire logic [5:0] low_len,
   output logic carrier
);
   irr_pkg::irr_car_state_t state_q;
   logic [5:0] cnt_q;

   assign carrier = (state_q == irr_pkg::IRR_CAR_HIGH);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= irr_pkg::IRR_CAR_IDLE;
         cnt_q <= 6'h00;
      end else if (ce) begin
         if (!run) begin
            state_q <= irr_pkg::IRR_CAR_IDLE;
            cnt_q <= 6'h00;
         end else begin
            case (state_q)
               irr_pkg::IRR_CAR_IDLE: begin
                  state_q <= irr_pkg::IRR_CAR_HIGH;
                  cnt_q <= 6'h00;
               end
               irr_pkg::IRR_CAR_HIGH: begin
                  if (tick) begin
                     if (cnt_q == high_len) begin
                        state_q <= irr_pkg::IRR_CAR_LOW;
                        cnt_q <= 6'h00;
                     end else begin
                        cnt_q <= cnt_q + 6'h01;
                     end
                  end
               end
               irr_pkg::IRR_CAR_LOW: begin
                  if (tick) begin
                     if (cnt_q == low_len) begin
                        state_q <= irr_pkg::IRR_CAR_HIGH;
                        cnt_q <= 6'h00;
                     end else begin
                        cnt_q <= cnt_q + 6'h01;
                     end
                  end
               end
               default: begin
                  state_q <= irr_pkg::IRR_CAR_IDLE;
                  cnt_q <= 6'h00;
               end
            endcase
         end
      end
   end
endmodule : irr_carrier_gen

// *** verilog/irr_remote_unit.sv ***
// Purpose: Infrared remote pulse unit with APB register access.
// Assumes: ir_in_pin is synchronous to clk; APB3 master with 32-bit data.
// Notes: Each APB access takes one wait state; pready and prdata come from flops.
`include "irr_defines.svh"
module irr_remote_unit (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ir_in_pin,
   output logic ir_out_pin,
   output logic irq
);
   logic [3:0] car_div_q;
   logic [3:0] len_div_q;
   logic dir_q;
   logic en_q;
   logic [5:0] car_lo_q;
   logic [5:0] car_hi_q;
   logic [7:0] len_q;
   logic level_q;
   logic [2:0] flag_q;
   logic [2:0] irq_en_q;
   logic samp_q;
   logic lvl_q;
   logic ir_out_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   logic addr_ok;
   logic hit_cfg;
   logic hit_car;
   logic hit_cnt;
   logic hit_irq;
   logic wr_done;
   logic [15:0] rd_data;
   logic tx_act;
   logic rx_act;
   logic car_tick;
   logic len_tick;
   logic carrier;
   logic unf_set;
   logic rise_set;
   logic fall_set;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ir_out_pin = ir_out_q;
   assign irq = irq_q;

   assign tx_act = en_q & ~dir_q;
   assign rx_act = en_q & dir_q;

   // A register word matches when the index bits of the address equal its index.
   function automatic logic irr_idx_hit(input logic [31:0] addr, input logic [15:0] idx);
      return (addr[17:2] == idx);
   endfunction : irr_idx_hit

   // Register index sits in paddr[17:2]; anything outside the four words is unmapped.
   assign hit_cfg = irr_idx_hit(paddr, `IRR_IDX_CONFIG);
   assign hit_car = irr_idx_hit(paddr, `IRR_IDX_CARRIER);
   assign hit_cnt = irr_idx_hit(paddr, `IRR_IDX_COUNTER);
   assign hit_irq = irr_idx_hit(paddr, `IRR_IDX_IRQ);
   assign addr_ok = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'b00) &&
                    (hit_cfg || hit_car || hit_cnt || hit_irq);
   // Writes land only at the completing edge, when pready is seen high.
   assign wr_done = psel & penable & pready_q & pwrite & addr_ok;

   always_comb begin
      rd_data = 16'h0000;
      if (hit_cfg) begin
         rd_data[`IRR_CFG_CDIV_HI:`IRR_CFG_CDIV_LO] = car_div_q;
         rd_data[`IRR_CFG_LDIV_HI:`IRR_CFG_LDIV_LO] = len_div_q;
         rd_data[`IRR_CFG_DIR] = dir_q;
         rd_data[`IRR_CFG_EN] = en_q;
      end else if (hit_car) begin
         rd_data[`IRR_CAR_LO_HI:`IRR_CAR_LO_LO] = car_lo_q;
         rd_data[`IRR_CAR_HI_HI:`IRR_CAR_HI_LO] = car_hi_q;
      end else if (hit_cnt) begin
         rd_data[`IRR_CNT_LEN_HI:`IRR_CNT_LEN_LO] = len_q;
         rd_data[`IRR_CNT_LEVEL] = level_q;
      end else if (hit_irq) begin
         rd_data[`IRR_IRQ_FLAG_HI:`IRR_IRQ_FLAG_LO] = flag_q;
         rd_data[`IRR_IRQ_EN_HI:`IRR_IRQ_EN_LO] = irq_en_q;
      end
   end

   // Bus answer: first access cycle captures read data, second completes.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~addr_ok;
            prdata_q <= addr_ok ? {16'h0000, rd_data} : 32'h0000_0000;
         end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         car_div_q <= `IRR_RST_DIV;
         len_div_q <= `IRR_RST_DIV;
         dir_q <= 1'b0;
         en_q <= 1'b0;
      end else if (ce && wr_done && hit_cfg) begin
         car_div_q <= pwdata[`IRR_CFG_CDIV_HI:`IRR_CFG_CDIV_LO];
         len_div_q <= pwdata[`IRR_CFG_LDIV_HI:`IRR_CFG_LDIV_LO];
         dir_q <= pwdata[`IRR_CFG_DIR];
         en_q <= pwdata[`IRR_CFG_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         car_lo_q <= `IRR_RST_CAR;
         car_hi_q <= `IRR_RST_CAR;
      end else if (ce && wr_done && hit_car) begin
         car_lo_q <= pwdata[`IRR_CAR_LO_HI:`IRR_CAR_LO_LO];
         car_hi_q <= pwdata[`IRR_CAR_HI_HI:`IRR_CAR_HI_LO];
      end
   end

   // Both dividers restart while the unit is off, so the first tick after enabling is
   // one full divided period away, except at ratio 1/1.
   irr_clk_div u_car_div (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .run(en_q),
      .sel(car_div_q),
      .tick(car_tick)
   );

   irr_clk_div u_len_div (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .run(en_q),
      .sel(len_div_q),
      .tick(len_tick)
   );

   irr_carrier_gen u_carrier (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .run(tx_act & level_q),
      .tick(car_tick),
      .high_len(car_hi_q),
      .low_len(car_lo_q),
      .carrier(carrier)
   );

   // Loading zero does not raise an underflow; only counting down onto zero does.
   assign unf_set = en_q & len_tick & (len_q == 8'h01) & ~(wr_done & hit_cnt);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         len_q <= `IRR_RST_LEN;
      end else if (ce) begin
         if (wr_done && hit_cnt) begin
            len_q <= pwdata[`IRR_CNT_LEN_HI:`IRR_CNT_LEN_LO];
         end else if (en_q && len_tick && (len_q != 8'h00)) begin
            len_q <= len_q - 8'h01;
         end
      end
   end

   // In receive mode the filtered level overrides any software write.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         level_q <= 1'b0;
      end else if (ce) begin
         if (rx_act) begin
            level_q <= lvl_q;
         end else if (wr_done && hit_cnt) begin
            level_q <= pwdata[`IRR_CNT_LEVEL];
         end
      end
   end

   // Edge filter: a new level must be seen on two successive carrier-clock samples.
   // Outside receive mode both stages follow the pin, so enabling gives no false edge.
   assign rise_set = rx_act & car_tick & ir_in_pin & samp_q & ~lvl_q;
   assign fall_set = rx_act & car_tick & ~ir_in_pin & ~samp_q & lvl_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         samp_q <= 1'b0;
         lvl_q <= 1'b0;
      end else if (ce) begin
         if (!rx_act) begin
            samp_q <= ir_in_pin;
            lvl_q <= ir_in_pin;
         end else if (car_tick) begin
            samp_q <= ir_in_pin;
            if (ir_in_pin == samp_q) begin
               lvl_q <= ir_in_pin;
            end
         end
      end
   end

   // Flag bits in order fall, rise, underflow; a set in the clearing cycle survives.
   assign flag_set = {fall_set, rise_set, unf_set};
   assign flag_clr = (wr_done && hit_irq) ? pwdata[`IRR_IRQ_FLAG_HI:`IRR_IRQ_FLAG_LO] : 3'h0;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_q <= 3'h0;
      end else if (ce) begin
         flag_q <= (flag_q & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_en_q <= 3'h0;
      end else if (ce && wr_done && hit_irq) begin
         irq_en_q <= pwdata[`IRR_IRQ_EN_HI:`IRR_IRQ_EN_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= |(flag_q & irq_en_q);
      end
   end

   // The pin is registered, so it trails the carrier state by one cycle.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ir_out_q <= 1'b0;
      end else if (ce) begin
         ir_out_q <= tx_act & level_q & carrier;
      end
   end
endmodule : irr_remote_unit

// *** verif/irr_ir_partner.sv ***
// Purpose: IR receiver and LED stand-in at the far side of the unit.
// Assumes: The bench sets level and glitch right after a clock edge.
// Notes: A glitch inverts the line for one cycle only.
module irr_ir_partner (
   input wire logic clk,
   input wire logic level,
   input wire logic glitch,
   input wire logic ir_out_pin,
   output logic ir_in_pin,
   output logic [15:0] led_pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q = 1'b0;
   initial ir_in_pin = 1'b0;
   initial led_pulses = 16'h0;
   always @(posedge clk) begin
      ir_in_pin <= level ^ glitch;
      last_q <= ir_out_pin;
      if (ir_out_pin && !last_q) begin
         led_pulses <= led_pulses + 16'h1;
      end
   end
endmodule : irr_ir_partner

// *** verif/irr_remote_unit_sva.sv ***
// Purpose: Port checks of the IR remote pulse unit.
// Assumes: ce stays high.
// Notes: Enable shadows follow completed APB writes.
module irr_remote_unit_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ir_out_pin,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic acc;
   logic rdy;
   logic tx_q;
   logic [2:0] ie_q;
   logic [1:0] off_q;
   assign rdy = psel && penable && pready;
   assign acc = rdy && pwrite && !pslverr;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_q <= 1'b0;
         ie_q <= 3'h0;
      end else if (acc && paddr == 32'h00014d00) begin
         tx_q <= pwdata[0] && !pwdata[1];
      end else if (acc && paddr == 32'h00014d18) begin
         ie_q <= pwdata[2:0];
      end
   end
   // Output may lag a stop by one cycle, so only a settled stop is judged.
   always_ff @(posedge clk) begin
      if (!rstn || tx_q) begin
         off_q <= 2'h0;
      end else if (off_q != 2'h3) begin
         off_q <= off_q + 2'h1;
      end
   end
   AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_HI_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   AST_MISALIGN: assert property (rdy && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access accepted");
   AST_MAPPED: assert property (rdy && paddr == 32'h00014d08 |-> !pslverr)
      else $error("mapped access refused");
   AST_CFG_RSVD: assert property (rdy && !pwrite && paddr == 32'h00014d00
      |-> prdata[7:2] == 6'h0) else $error("config reserved bits set");
   AST_CNT_RSVD: assert property (rdy && !pwrite && paddr == 32'h00014d10
      |-> prdata[7:1] == 7'h0) else $error("counter reserved bits set");
   AST_INT_RSVD: assert property (rdy && !pwrite && paddr == 32'h00014d18
      |-> prdata[15:11] == 5'h0 && prdata[7:3] == 5'h0) else $error("irq reserved bits set");
   AST_IDLE_OUT: assert property (off_q == 2'h3 |-> !ir_out_pin)
      else $error("output active outside transmit");
   AST_IRQ_MASK: assert property (ie_q == 3'h0 && $past(ie_q) == 3'h0 |-> !irq)
      else $error("request with all causes masked");
endmodule : irr_remote_unit_sva
bind irr_remote_unit irr_remote_unit_sva u_sva (.clk, .rstn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .ir_out_pin, .irq);

// *** verif/ir_remote_pulse_unit_tb.sv ***
// Purpose: Self-checking bench of the IR remote pulse unit.
// Assumes: ce held high; byte address is four times the register index.
// Notes: Carrier codes stop at 10 to keep the run short.
`include "irr_defines.svh"
module ir_remote_pulse_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CFG = 32'(`IRR_IDX_CONFIG) * 32'h4;
   localparam logic [31:0] A_CAR = 32'(`IRR_IDX_CARRIER) * 32'h4;
   localparam logic [31:0] A_CNT = 32'(`IRR_IDX_COUNTER) * 32'h4;
   localparam logic [31:0] A_INT = 32'(`IRR_IDX_IRQ) * 32'h4;
   logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ir_in_pin, ir_out_pin, irq, err;
   logic level = 1'b0, glitch = 1'b0;
   logic [15:0] led_pulses;
   int err_total = 0, samples_checked = 0;
   always #10 clk = ~clk;
   irr_remote_unit dut (.clk(clk), .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ir_in_pin(ir_in_pin), .ir_out_pin(ir_out_pin), .irq(irq));
   irr_ir_partner u_ir (.clk(clk), .level(level), .glitch(glitch), .ir_out_pin(ir_out_pin),
      .ir_in_pin(ir_in_pin), .led_pulses(led_pulses));
   task results();
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task apb(input logic w, input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdc(input logic [31:0] a, input logic [15:0] exp);
      apb(1'b0, a, 16'h0);
      chk(rd, {16'h0, exp});
   endtask : rdc
   task run_len(input logic v, output int n);
      n = 0;
      while (ir_out_pin === v && n < 40000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 40000), 32'h1);
   endtask : run_len
   task t_regs();
      rdc(A_CFG, 16'h0000);
      rdc(A_CAR, 16'h0000);
      rdc(A_CNT, 16'h0000);
      rdc(A_INT, 16'h0000);
      apb(1'b0, A_CFG + 32'h4, 16'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, A_CFG, 16'hff00);
      rdc(A_CFG, 16'hff00);
      apb(1'b1, A_CFG, 16'h0002);
      rdc(A_CFG, 16'h0002);
      apb(1'b1, A_CAR, 16'h3f3f);
      rdc(A_CAR, 16'h3f3f);
      apb(1'b1, A_CNT, 16'hff00);
      rdc(A_CNT, 16'hff00);
      apb(1'b1, A_INT, 16'h0707);
      rdc(A_INT, 16'h0007);
      apb(1'b1, A_INT, 16'h0000);
      apb(1'b1, A_CNT, 16'h0000);
      apb(1'b1, A_CFG, 16'h0000);
   endtask : t_regs
   task t_counter();
      int n;
      n = 0;
      apb(1'b1, A_INT, 16'h0700);
      apb(1'b1, A_INT, 16'h0001);
      apb(1'b1, A_CFG, 16'h0f01);
      apb(1'b1, A_CNT, 16'hff00);
      cyc(20);
      rdc(A_CNT, 16'hff00);
      apb(1'b1, A_CFG, 16'h0000);
      apb(1'b1, A_CNT, 16'h0000);
      apb(1'b1, A_CFG, 16'h0201);
      apb(1'b1, A_CNT, 16'h0300);
      chk(32'(irq), 32'h0);
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n > 6 && n < 18), 32'h1);
      rdc(A_CNT, 16'h0000);
      cyc(20);
      rdc(A_CNT, 16'h0000);
      rdc(A_INT, 16'h0101);
      apb(1'b1, A_INT, 16'h0000);
      rdc(A_INT, 16'h0100);
      chk(32'(irq), 32'h0);
      apb(1'b1, A_INT, 16'h0100);
      rdc(A_INT, 16'h0000);
      apb(1'b1, A_CFG, 16'h0000);
   endtask : t_counter
   task t_rx();
      apb(1'b1, A_INT, 16'h0706);
      apb(1'b1, A_CFG, 16'h0203);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
      cyc(10);
      rdc(A_INT, 16'h0006);
      level <= 1'b1;
      cyc(10);
      chk(32'(irq), 32'h1);
      rdc(A_INT, 16'h0206);
      rdc(A_CNT, 16'h0001);
      apb(1'b1, A_CNT, 16'hff00);
      apb(1'b1, A_INT, 16'h0206);
      cyc(20);
      level <= 1'b0;
      cyc(10);
      apb(1'b0, A_CNT, 16'h0);
      chk(32'(rd[15:8] inside {[8'he8 : 8'hf8]}), 32'h1);
      chk(32'(rd[0]), 32'h0);
      rdc(A_INT, 16'h0406);
      apb(1'b1, A_CFG, 16'h0000);
      apb(1'b1, A_INT, 16'h0700);
      apb(1'b1, A_CNT, 16'h0000);
   endtask : t_rx
   task t_carrier();
      int n;
      int lo;
      int hi;
      for (int k = 0; k < 11; k++) begin
         apb(1'b1, A_CAR, {2'h0, 6'(3 - k % 4), 2'h0, 6'(k % 4)});
         apb(1'b1, A_CFG, {4'(k), 12'h001});
         apb(1'b1, A_CNT, 16'h0001);
         run_len(1'b0, n);
         run_len(1'b1, n);
         run_len(1'b0, lo);
         run_len(1'b1, hi);
         chk(32'(hi), 32'((k % 4 + 1) << k));
         chk(32'(lo), 32'((4 - k % 4) << k));
         apb(1'b1, A_CNT, 16'h0000);
         apb(1'b1, A_CFG, 16'h0000);
      end
      apb(1'b1, A_CFG, 16'h0001);
      cyc(4);
      n = 32'(led_pulses);
      cyc(40);
      chk(32'(led_pulses), 32'(n));
      apb(1'b1, A_CFG, 16'h0000);
   endtask : t_carrier
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_counter();
      t_rx();
      t_carrier();
      results();
   end
   initial begin
      #1500000;
      err_total++;
      $display("Error %0t: watchdog expired", $time);
      results();
   end
endmodule : ir_remote_pulse_unit_tb
